// *** include/scc_pkg.sv ***
// constants shared by the serial control register block
package scc_pkg;
  // register indices; byte address is four times the index
  localparam int unsigned CTRL3_IDX = 6;       // third control register
  localparam int unsigned DATA_IDX  = 7;       // transmit/receive data
  localparam int unsigned MODE_IDX  = 8;       // character and wiring mode
  localparam int unsigned CTRL3_ADDR = CTRL3_IDX * 4;
  localparam int unsigned DATA_ADDR  = DATA_IDX * 4;
  localparam int unsigned MODE_ADDR  = MODE_IDX * 4;

  // third control register fields
  localparam int unsigned C3_RX_NINTH  = 7;    // read only
  localparam int unsigned C3_TX_NINTH  = 6;
  localparam int unsigned C3_PIN_DIR   = 5;
  localparam int unsigned C3_TX_INV    = 4;
  localparam int unsigned C3_OVR_IE    = 3;
  localparam int unsigned C3_NOISE_IE  = 2;
  localparam int unsigned C3_FRAME_IE  = 1;
  localparam int unsigned C3_PARITY_IE = 0;
  localparam logic [7:0]  C3_RESET     = 8'h00;
  localparam logic [7:0]  C3_WR_MASK   = 8'h7f;  // bit 7 ignores writes

  // mode register fields
  localparam int unsigned MODE_NINE  = 0;      // 9-bit characters
  localparam int unsigned MODE_LOOP  = 1;      // loop mode select
  localparam int unsigned MODE_RECEIVER_SOURCE_SELECT  = 2;      // receiver source select
  localparam int unsigned MODE_W     = 3;
  localparam logic [2:0]  MODE_RESET = 3'h0;

  // character widths
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned WORD_W = 9;
endpackage

// *** rtl/scc_buf2.sv ***
// two-entry transmit word buffer with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module scc_buf2 #(
  parameter int unsigned WIDTH = 9,
  parameter int unsigned DEPTH = 2
) (
  // clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // filling side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  typedef struct packed {
    logic [WIDTH-1:0] head;
    logic [WIDTH-1:0] tail;
    logic             head_v;
    logic             tail_v;
  } scc_buf_st_t;

  scc_buf_st_t st_reg;
  scc_buf_st_t st_next;
  logic        push;
  logic        pop;

  // structure only serves two entries
  if (DEPTH != 2 || WIDTH < 1) begin : g_bad
    $error("scc_buf2 supports DEPTH 2 and WIDTH of at least 1");
  end

  // handshakes seen from both sides
  assign in_ready  = !st_reg.tail_v;
  assign out_valid = st_reg.head_v;
  assign out_data  = st_reg.head;
  assign push      = in_valid && !st_reg.tail_v;
  assign pop       = st_reg.head_v && out_ready;

  // head always holds the oldest word
  always_comb begin
    st_next = st_reg;
    if (pop) begin
      st_next.head   = st_reg.tail;
      st_next.head_v = st_reg.tail_v;
      st_next.tail_v = 1'b0;
    end
    if (push) begin
      if (!st_next.head_v) begin
        st_next.head   = in_data;
        st_next.head_v = 1'b1;
      end else begin
        st_next.tail   = in_data;
        st_next.tail_v = 1'b1;
      end
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // a full buffer never shows an empty head
  chk_buf_full_order: assert property (@(posedge pclk) disable iff (!presetn)
    st_reg.tail_v |-> st_reg.head_v)
    else $error("buffer tail valid while head empty");
endmodule
`default_nettype wire

// *** rtl/scc_ctrl3.sv ***
// third control register of the serial port with apb access
//
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module scc_ctrl3 #(
  parameter int unsigned ADDR_W = 12
) (
  // clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic                   pready,
  output logic [31:0]            prdata,
  output logic                   pslverr,
  // receiver side
  input  wire logic              rx_word_valid,
  input  wire logic [8:0]        rx_word,
  output logic                   rx_data_read,
  // error flags from the receiver
  input  wire logic              overrun_flag,
  input  wire logic              noise_flag,
  input  wire logic              framing_error_flag,
  input  wire logic              parity_error_flag,
  output logic                   err_irq,
  // words to the transmitter
  output logic                   tx_word_valid,
  input  wire logic              tx_word_ready,
  output logic [8:0]             tx_word_data,
  // transmit pin
  input  wire logic              tx_line,
  output logic                   txd_out,
  output logic                   txd_oe_n,
  input  wire logic              txd_in,
  output logic                   single_wire_rx
);
  typedef struct packed {
    logic [7:0]  ctrl3;
    logic [2:0]  mode;
    logic [7:0]  rx_data;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
    logic        rx_read;
    logic        txd;
    logic        txd_oe_n;
    logic        pin_s1;
    logic        pin_s2;
    logic        irq;
  } scc_ctrl3_st_t;

  scc_ctrl3_st_t st_reg;
  scc_ctrl3_st_t st_next;

  logic       sel_ctrl3;
  logic       sel_data;
  logic       sel_mode;
  logic       done;
  logic       push;
  logic       buf_in_ready;
  logic       nine;
  logic       single_wire;
  logic [8:0] push_word;
  logic [3:0] flags;
  logic [3:0] enables;

  if (ADDR_W < 6) begin : g_bad
    $error("scc_ctrl3 needs ADDR_W of at least 6");
  end

  // address decode and transfer completion
  assign sel_ctrl3 = paddr == ADDR_W'(scc_pkg::CTRL3_ADDR);
  assign sel_data  = paddr == ADDR_W'(scc_pkg::DATA_ADDR);
  assign sel_mode  = paddr == ADDR_W'(scc_pkg::MODE_ADDR);
  assign done      = psel && penable && st_reg.pready;

  // mode and flag views
  assign nine        = st_reg.mode[scc_pkg::MODE_NINE];
  assign single_wire = st_reg.mode[scc_pkg::MODE_LOOP]
                    && st_reg.mode[scc_pkg::MODE_RECEIVER_SOURCE_SELECT];
  assign flags   = {overrun_flag, noise_flag, framing_error_flag,
                    parity_error_flag};
  assign enables = {st_reg.ctrl3[scc_pkg::C3_OVR_IE],
                    st_reg.ctrl3[scc_pkg::C3_NOISE_IE],
                    st_reg.ctrl3[scc_pkg::C3_FRAME_IE],
                    st_reg.ctrl3[scc_pkg::C3_PARITY_IE]};

  // nine-bit word built from the held ninth bit and the byte
  assign push_word = {nine && st_reg.ctrl3[scc_pkg::C3_TX_NINTH],
                      pwdata[scc_pkg::BYTE_W-1:0]};
  assign push      = done && pwrite && sel_data;

  // next-state logic
  always_comb begin
    st_next         = st_reg;
    st_next.rx_read = 1'b0;
    // answer once; a data write waits for buffer room
    if (psel && penable && !st_reg.pready) begin
      if (!(pwrite && sel_data && !buf_in_ready)) begin
        st_next.pready  = 1'b1;
        st_next.pslverr = !(sel_ctrl3 || sel_data || sel_mode);
        st_next.prdata  = 32'h0000_0000;
        if (!pwrite && sel_ctrl3) begin
          st_next.prdata[7:0] = st_reg.ctrl3;
        end
        if (!pwrite && sel_data) begin
          st_next.prdata[7:0] = st_reg.rx_data;
        end
        if (!pwrite && sel_mode) begin
          st_next.prdata[scc_pkg::MODE_W-1:0] = st_reg.mode;
        end
      end
    end else begin
      st_next.pready  = 1'b0;
      st_next.pslverr = 1'b0;
    end
    // write effects at the completing edge
    if (done && pwrite && sel_ctrl3) begin
      st_next.ctrl3 = (st_reg.ctrl3 & ~scc_pkg::C3_WR_MASK)
                    | (pwdata[7:0] & scc_pkg::C3_WR_MASK);
    end
    if (done && pwrite && sel_mode) begin
      st_next.mode = pwdata[scc_pkg::MODE_W-1:0];
    end
    // data read completes the receiver's flag clearing
    if (done && !pwrite && sel_data) begin
      st_next.rx_read = 1'b1;
    end
    // received character replaces byte and ninth bit
    if (rx_word_valid) begin
      st_next.rx_data = rx_word[scc_pkg::BYTE_W-1:0];
      st_next.ctrl3[scc_pkg::C3_RX_NINTH] =
        nine && rx_word[scc_pkg::WORD_W-1];
    end
    // transmit pin polarity and direction
    st_next.txd = tx_line ^ st_reg.ctrl3[scc_pkg::C3_TX_INV];
    st_next.txd_oe_n = single_wire
                     && !st_reg.ctrl3[scc_pkg::C3_PIN_DIR];
    // pin synchroniser
    st_next.pin_s1 = txd_in;
    st_next.pin_s2 = st_reg.pin_s1;
    // gated error request
    st_next.irq = |(flags & enables);
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg          <= '0;
      st_reg.ctrl3    <= scc_pkg::C3_RESET;
      st_reg.mode     <= scc_pkg::MODE_RESET;
      st_reg.txd_oe_n <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  // transmit word buffer
  scc_buf2 #(
    .WIDTH (scc_pkg::WORD_W),
    .DEPTH (2)
  ) u_txbuf (
    .pclk      (pclk),
    .presetn   (presetn),
    .in_valid  (push),
    .in_ready  (buf_in_ready),
    .in_data   (push_word),
    .out_valid (tx_word_valid),
    .out_ready (tx_word_ready),
    .out_data  (tx_word_data)
  );

  // outputs from flops
  assign pready         = st_reg.pready;
  assign prdata         = st_reg.prdata;
  assign pslverr        = st_reg.pslverr;
  assign rx_data_read   = st_reg.rx_read;
  assign err_irq        = st_reg.irq;
  assign txd_out        = st_reg.txd;
  assign txd_oe_n       = st_reg.txd_oe_n;
  assign single_wire_rx = st_reg.pin_s2;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_ctrl3_write_bits: assert property (
    done && pwrite && sel_ctrl3 && !rx_word_valid
    |=> st_reg.ctrl3[6:0] == $past(pwdata[6:0]))
    else $error("control write not stored");

  chk_rx_ninth_bit: assert property (
    rx_word_valid |=> st_reg.ctrl3[7] == $past(nine && rx_word[8]))
    else $error("received ninth bit wrong");

  chk_tx_word_out: assert property (
    push && !tx_word_valid |=> tx_word_valid
      && tx_word_data == $past(push_word))
    else $error("transmit word not forwarded");

  chk_tx_ninth_hold: assert property (
    !(done && pwrite && sel_ctrl3) |=> $stable(st_reg.ctrl3[6]))
    else $error("transmit ninth bit changed");

  chk_pin_direction: assert property (
    single_wire ##1 1 |-> txd_oe_n == !$past(st_reg.ctrl3[5]))
    else $error("single wire direction wrong");

  chk_tx_invert: assert property (
    1 |=> txd_out == ($past(tx_line) ^ $past(st_reg.ctrl3[4])))
    else $error("transmit polarity wrong");

  chk_overrun_irq: assert property (
    overrun_flag && st_reg.ctrl3[3] |=> err_irq)
    else $error("overrun request missing");

  chk_error_mask: assert property (
    (flags & enables) == 4'h0 |=> !err_irq)
    else $error("masked flag raised request");

  chk_irq_or_gate: assert property (
    $changed(flags & enables) |=> err_irq == $past(|(flags & enables)))
    else $error("request not or of gated flags");

  chk_apb_single: assert property (
    pready |=> !pready)
    else $error("pready held longer than one cycle");
endmodule
`default_nettype wire

// *** verification/scc_far_tx.sv ***
// far-end transmitter model: drains words and drives the serial line
`timescale 1ns/1ps
`default_nettype none
module scc_far_tx (
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // word handshake
  input  wire logic       stall,
  input  wire logic       tx_word_valid,
  output logic            tx_word_ready,
  input  wire logic [8:0] tx_word_data,
  // uninverted serial line
  output logic            tx_line
);
  // refuses words while the bench asks for a stall
  assign tx_word_ready = !stall;
  // line idles high, then shows bit 0 of the last word taken
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) tx_line <= 1'b1;
    else if (tx_word_valid && tx_word_ready) tx_line <= tx_word_data[0];
  end
endmodule
`default_nettype wire

// *** verification/test_serial_port_control_three.sv ***
// self-checking bench for the third serial control register
`timescale 1ns/1ps
`default_nettype none
module test_serial_port_control_three;
  typedef struct {logic w; logic [11:0] a; logic [31:0] d, e; logic err;} scc_row_t;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic rx_word_valid, rx_data_read, err_irq, er, stall, done3;
  logic [8:0] rx_word, tx_word_data;
  logic [3:0] flags;
  logic tx_word_valid, tx_word_ready, tx_line, txd_out, txd_oe_n;
  logic txd_in, single_wire_rx;
  logic [8:0] got[$];
  int failures, samples_checked, cyc, rd_pulses, i, n;
  scc_row_t rows[10];
  // device under test
  scc_ctrl3 i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .rx_word_valid(rx_word_valid), .rx_word(rx_word),
    .rx_data_read(rx_data_read), .overrun_flag(flags[3]),
    .noise_flag(flags[2]), .framing_error_flag(flags[1]),
    .parity_error_flag(flags[0]), .err_irq(err_irq),
    .tx_word_valid(tx_word_valid), .tx_word_ready(tx_word_ready),
    .tx_word_data(tx_word_data), .tx_line(tx_line), .txd_out(txd_out),
    .txd_oe_n(txd_oe_n), .txd_in(txd_in), .single_wire_rx(single_wire_rx));
  // far end of the word stream
  scc_far_tx i_far (.pclk(pclk), .presetn(presetn), .stall(stall),
    .tx_word_valid(tx_word_valid), .tx_word_ready(tx_word_ready),
    .tx_word_data(tx_word_data), .tx_line(tx_line));
  // clock
  always #2 pclk = ~pclk;
  // monitor pulses and popped words, cut a hang short
  always @(posedge pclk) begin
    if (rx_data_read === 1'b1) rd_pulses++;
    if (tx_word_valid === 1'b1 && tx_word_ready === 1'b1) got.push_back(tx_word_data);
    cyc++;
    if (cyc == 5000) begin
      failures++;
      summarize();
    end
  end
  // one apb transfer, waits for pready at a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // value comparison
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  // verdict and end of run
  task automatic summarize();
    if (failures == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // main sequence
  initial begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0;
    pwdata = 0; rx_word_valid = 0; rx_word = 0; flags = 0; stall = 0;
    txd_in = 0; failures = 0; samples_checked = 0; cyc = 0; rd_pulses = 0;
    rows = '{'{1, 12'h018, 32'hff, 0, 0}, '{0, 12'h018, 0, 32'h7f, 0},
             '{1, 12'h018, 32'h00, 0, 0}, '{0, 12'h018, 0, 32'h00, 0},
             '{1, 12'h020, 32'h07, 0, 0}, '{0, 12'h020, 0, 32'h07, 0},
             '{1, 12'h020, 32'h00, 0, 0}, '{1, 12'h040, 32'h01, 0, 1},
             '{0, 12'h040, 0, 32'h00, 1}, '{0, 12'h000, 0, 32'h00, 1}};
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(0, 12'h018, 0); chk("ctrl3 reset", 32'h0, rd);
    // table of ordinary accesses
    for (i = 0; i < 10; i++) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      chk("pslverr", {31'h0, rows[i].err}, {31'h0, er});
      if (!rows[i].w) chk("prdata", rows[i].e, rd);
    end
    // each error flag against its own enable
    for (i = 0; i < 4; i++) begin
      apb(1, 12'h018, 32'h1 << i);
      flags <= 4'hf ^ (4'h1 << i);
      repeat (3) @(posedge pclk);
      chk("irq masked", 32'h0, {31'h0, err_irq});
      flags <= 4'h1 << i;
      repeat (3) @(posedge pclk);
      chk("irq raised", 32'h1, {31'h0, err_irq});
      flags <= 4'h0;
    end
    // idle line with and without inversion
    for (i = 0; i < 2; i++) begin
      apb(1, 12'h018, i << 4);
      repeat (3) @(posedge pclk);
      chk("txd_out", {31'h0, tx_line ^ i[0]}, {31'h0, txd_out});
    end
    // loop select alone keeps the pin driven
    apb(1, 12'h020, 32'h2);
    apb(1, 12'h018, 32'h0);
    repeat (3) @(posedge pclk);
    chk("pin loop only", 32'h0, {31'h0, txd_oe_n});
    // single-wire pin direction and receive sync
    apb(1, 12'h020, 32'h6); apb(1, 12'h018, 32'h0);
    txd_in <= 1'b1;
    repeat (4) @(posedge pclk);
    chk("pin input", 32'h1, {31'h0, txd_oe_n});
    chk("pin sync", 32'h1, {31'h0, single_wire_rx});
    apb(1, 12'h018, 32'h20);
    repeat (3) @(posedge pclk);
    chk("pin output", 32'h0, {31'h0, txd_oe_n});
    // nine-bit receive, ninth bit fetched before the byte
    apb(1, 12'h020, 32'h1);
    rx_word <= 9'h1a5; rx_word_valid <= 1'b1;
    @(posedge pclk);
    rx_word_valid <= 1'b0;
    @(posedge pclk);
    n = rd_pulses;
    apb(0, 12'h018, 0); chk("rx ninth", 32'h1, {31'h0, rd[7]});
    apb(0, 12'h01c, 0); chk("rx byte", 32'ha5, rd);
    repeat (3) @(posedge pclk);
    chk("read pulses", n + 1, rd_pulses);
    // nine-bit transmit into a stalled far end, ninth bit kept
    apb(1, 12'h018, 32'h40);
    stall <= 1'b1;
    apb(1, 12'h01c, 32'h55); apb(1, 12'h01c, 32'h66);
    done3 = 1'b0;
    fork
      begin apb(1, 12'h01c, 32'h77); done3 = 1'b1; end
      begin
        repeat (20) @(posedge pclk);
        chk("write stalled", 32'h0, {31'h0, done3});
        chk("none popped", 32'h0, got.size());
        stall <= 1'b0;
      end
    join
    repeat (6) @(posedge pclk);
    chk("words", 32'h3, got.size());
    for (i = 0; i < 3; i++) chk("tx word", 9'h155 + 9'h11 * i, got[i]);
    // mid-run reset clears a queued word and the registers
    stall <= 1'b1;
    apb(1, 12'h01c, 32'h12);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    chk("buffer reset", 32'h0, {31'h0, tx_word_valid});
    presetn <= 1'b1;
    stall <= 1'b0;
    @(posedge pclk);
    apb(0, 12'h018, 0);
    chk("ctrl3 rerun", 32'h0, rd);
    apb(0, 12'h020, 0);
    chk("mode reset", 32'h0, rd);
    // eight-bit mode sends no ninth bit although bit 6 is set
    apb(1, 12'h018, 32'h40);
    apb(1, 12'h01c, 32'h1ab);
    repeat (4) @(posedge pclk);
    chk("words plain", 32'h4, got.size());
    chk("tx word plain", 32'h0ab, got[3]);
    summarize();
  end
endmodule
`default_nettype wire
